// *** rtl/tio_pkg.sv ***
// Constants, types and reset state for the teach input and output status block
package tio_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_HZ = 16;
  localparam int TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int ADJ_MIN_S = 2;
  localparam int ADJ_MAX_S = 5;
  localparam int TOG_MAX_S = 10;
  localparam int LIT_S = 2;
  localparam int FAULT_S = 2;
  localparam int ADJ_RUN_S = 1;
  localparam logic [7:0] ADJ_MIN_T = 8'(ADJ_MIN_S * TICK_HZ);
  localparam logic [7:0] ADJ_MAX_T = 8'(ADJ_MAX_S * TICK_HZ);
  localparam logic [7:0] TOG_MAX_T = 8'(TOG_MAX_S * TICK_HZ);
  localparam logic [7:0] PULSE_SAT = 8'hFF;
  localparam logic [5:0] LIT_END = 6'(LIT_S * TICK_HZ - 1);
  localparam logic [5:0] FAULT_END = 6'(FAULT_S * TICK_HZ - 1);
  localparam logic [5:0] ADJ_END = 6'(ADJ_RUN_S * TICK_HZ - 1);

  // ----------------------------------------------------------------
  // Process values and thresholds, in per cent
  // ----------------------------------------------------------------
  localparam logic [6:0] PV_MIN = 7'h09;
  localparam logic [6:0] ADJ_OFS = 7'h04;
  localparam logic [6:0] MIN_HYST = 7'h02;
  localparam logic [6:0] SP_DFLT = 7'h3E;
  localparam logic [6:0] RP_DFLT = 7'h36;

  // ----------------------------------------------------------------
  // Parameter index writes and event codes
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_TEST = 8'h02;
  localparam logic [7:0] TEST1_SET = 8'hF0;
  localparam logic [7:0] TEST1_CLR = 8'hF1;
  localparam logic [7:0] TEST2_SET = 8'hF2;
  localparam logic [7:0] TEST2_CLR = 8'hF3;
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_HW = 16'h5000;
  localparam logic [15:0] CODE_PARAM = 16'h6320;
  localparam logic [15:0] CODE_SHORT = 16'h7710;
  localparam logic [15:0] CODE_TEST1 = 16'h8DFE;
  localparam logic [15:0] CODE_TEST2 = 16'h8DFF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FN_HNO = 2'h0,
    FN_HNC = 2'h1,
    FN_FNO = 2'h2,
    FN_FNC = 2'h3
  } tio_func_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_MEAS = 5'h02,
    ST_ADJ = 5'h04,
    ST_LIT = 5'h08,
    ST_FAULT = 5'h10
  } tio_st_t;

  typedef struct packed {
    logic green;
    logic yellow;
  } tio_led_t;

  typedef struct packed {
    logic hw;
    logic param;
    logic short_circ;
    logic test1;
    logic test2;
  } tio_evt_t;

  typedef struct packed {
    logic we;
    tio_func_t ou1;
    tio_func_t fn2;
    logic [6:0] sp1;
    logic [6:0] rp1;
    logic [6:0] sp2;
    logic [6:0] rp2;
  } tio_cfg_t;

  typedef struct packed {
    tio_st_t mode;
    logic [31:0] tick_cnt;
    logic [3:0] phase;
    logic [7:0] pulse;
    logic [5:0] hold;
    logic pin_d;
    logic amb;
    tio_func_t ou1;
    tio_func_t fn2;
    logic [6:0] sp1;
    logic [6:0] rp1;
    logic [6:0] sp2;
    logic [6:0] rp2;
    logic det1;
    logic det2;
    logic sw1;
    logic sw2;
    tio_led_t led1;
    tio_led_t ind2;
    tio_evt_t evt;
    logic [15:0] code;
  } tio_state_t;

  localparam tio_state_t ST_RESET = '{mode: ST_IDLE, ou1: FN_HNO, fn2: FN_HNC,
    sp1: SP_DFLT, rp1: RP_DFLT, sp2: SP_DFLT, rp2: RP_DFLT, default: '0};

endpackage

// *** rtl/tio_teach_status.sv ***
// Teach input timing, switching outputs, indicator patterns and event reporting
`timescale 1ns/10ps
`default_nettype none

module tio_teach_status #(
  parameter int unsigned TICK_CYC = tio_pkg::TICK_CYC
) (
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  input wire logic I_TEACH_EN,
  input wire logic I_TEACH_PIN,
  input wire logic [6:0] I_PROC_VAL,
  input wire logic I_SIG_AMBIG,
  input wire logic I_SHORT1,
  input wire logic I_SHORT2,
  input wire logic I_HW_FAIL,
  input wire tio_pkg::tio_cfg_t I_CFG,
  input wire logic I_FACTORY_RST,
  input wire logic I_IDX_WE,
  input wire logic [7:0] I_IDX_ADDR,
  input wire logic [7:0] I_IDX_DATA,
  output logic O_SW1,
  output logic O_SW2,
  output tio_pkg::tio_led_t O_LED1,
  output tio_pkg::tio_led_t O_IND2,
  output tio_pkg::tio_evt_t O_EVT,
  output logic [15:0] O_EVT_CODE,
  output tio_pkg::tio_func_t O_OU1,
  output tio_pkg::tio_func_t O_FN2,
  output logic O_TEACH_BUSY
);
  import tio_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic hyst(input logic [6:0] pv, input logic [6:0] sp,
                                input logic [6:0] rp, input logic prev);
    logic res;
    res = prev;
    if (pv >= sp) begin
      res = 1'b1;
    end else if (pv <= rp) begin
      res = 1'b0;
    end
    return res;
  endfunction

  function automatic logic sw_out(input tio_func_t fn, input logic det, input logic [6:0] pv,
                                  input logic [6:0] sp, input logic [6:0] rp);
    logic win;
    logic res;
    win = (pv >= rp) && (pv <= sp);
    case (fn)
      FN_HNO: res = det;
      FN_HNC: res = ~det;
      FN_FNO: res = win;
      FN_FNC: res = ~win;
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tio_state_t st_r;
  tio_state_t st_nxt;
  logic tick;
  logic rise;
  logic fall;
  logic lvl1;
  logic lvl2;
  logic show;
  logic blink2;
  logic blink8;
  logic dbl1;
  logic bad;
  tio_led_t led;

  assign tick = (st_r.tick_cnt == 32'(TICK_CYC - 1));
  assign rise = I_TEACH_PIN & ~st_r.pin_d;
  assign fall = ~I_TEACH_PIN & st_r.pin_d;
  assign blink2 = st_r.phase[2];
  assign blink8 = st_r.phase[0];
  assign dbl1 = ~st_r.phase[3] & ~st_r.phase[1];

  always_comb begin
    st_nxt = st_r;
    st_nxt.pin_d = I_TEACH_PIN;

    // ----------------------------------------------------------------
    // Time base at sixteen ticks per second
    // ----------------------------------------------------------------
    if (tick) begin
      st_nxt.tick_cnt = '0;
      st_nxt.phase = st_r.phase + 4'h1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 32'h1;
    end

    // ----------------------------------------------------------------
    // Configuration link writes
    // ----------------------------------------------------------------
    if (I_CFG.we) begin
      if ((I_CFG.sp1 > I_CFG.rp1) && (I_CFG.sp2 > I_CFG.rp2)) begin
        st_nxt.ou1 = I_CFG.ou1;
        st_nxt.fn2 = I_CFG.fn2;
        st_nxt.sp1 = I_CFG.sp1;
        st_nxt.rp1 = I_CFG.rp1;
        st_nxt.sp2 = I_CFG.sp2;
        st_nxt.rp2 = I_CFG.rp2;
        st_nxt.evt.param = 1'b0;
      end else begin
        st_nxt.evt.param = 1'b1;
      end
    end
    if (I_FACTORY_RST) begin
      st_nxt.ou1 = ST_RESET.ou1;
      st_nxt.fn2 = ST_RESET.fn2;
      st_nxt.sp1 = ST_RESET.sp1;
      st_nxt.rp1 = ST_RESET.rp1;
      st_nxt.sp2 = ST_RESET.sp2;
      st_nxt.rp2 = ST_RESET.rp2;
      st_nxt.evt.param = 1'b0;
    end
    if (I_IDX_WE && (I_IDX_ADDR == IDX_TEST)) begin
      case (I_IDX_DATA)
        TEST1_SET: st_nxt.evt.test1 = 1'b1;
        TEST1_CLR: st_nxt.evt.test1 = 1'b0;
        TEST2_SET: st_nxt.evt.test2 = 1'b1;
        TEST2_CLR: st_nxt.evt.test2 = 1'b0;
        default: st_nxt.evt.test1 = st_nxt.evt.test1;
      endcase
    end
    st_nxt.evt.hw = I_HW_FAIL;
    st_nxt.evt.short_circ = I_SHORT1 | I_SHORT2;

    // ----------------------------------------------------------------
    // Teach sequence
    // ----------------------------------------------------------------
    bad = 1'b0;
    case (st_r.mode)
      ST_IDLE: begin
        if (I_TEACH_EN && rise) begin
          st_nxt.mode = ST_MEAS;
          st_nxt.pulse = '0;
          st_nxt.amb = 1'b0;
        end
      end
      ST_MEAS: begin
        if (tick && (st_r.pulse != PULSE_SAT)) begin
          st_nxt.pulse = st_r.pulse + 8'h01;
        end
        st_nxt.amb = st_r.amb | I_SIG_AMBIG;
        st_nxt.hold = '0;
        if (!I_TEACH_EN) begin
          st_nxt.mode = ST_IDLE;
        end else if (fall) begin
          bad = st_r.amb | (st_r.fn2 == FN_FNO) | (st_r.fn2 == FN_FNC);
          if ((st_r.pulse <= ADJ_MIN_T) || (st_r.pulse == ADJ_MAX_T) ||
              (st_r.pulse >= TOG_MAX_T)) begin
            bad = 1'b1;
          end
          if ((st_r.pulse < ADJ_MAX_T) && (I_PROC_VAL < PV_MIN)) begin
            bad = 1'b1;
          end
          if (bad) begin
            st_nxt.mode = ST_FAULT;
          end else if (st_r.pulse < ADJ_MAX_T) begin
            st_nxt.mode = ST_ADJ;
          end else begin
            st_nxt.fn2 = (st_r.fn2 == FN_HNC) ? FN_HNO : FN_HNC;
            st_nxt.mode = ST_LIT;
          end
        end
      end
      ST_ADJ: begin
        if (tick) begin
          st_nxt.hold = st_r.hold + 6'h01;
          if (st_r.hold == ADJ_END) begin
            st_nxt.sp2 = I_PROC_VAL - ADJ_OFS;
            st_nxt.rp2 = I_PROC_VAL - ADJ_OFS - MIN_HYST;
            st_nxt.hold = '0;
            st_nxt.mode = ST_LIT;
          end
        end
      end
      ST_LIT: begin
        if (tick) begin
          st_nxt.hold = st_r.hold + 6'h01;
          if (st_r.hold == LIT_END) begin
            st_nxt.mode = ST_IDLE;
          end
        end
      end
      ST_FAULT: begin
        if (tick) begin
          st_nxt.hold = st_r.hold + 6'h01;
          if (st_r.hold == FAULT_END) begin
            st_nxt.mode = ST_IDLE;
          end
        end
      end
      default: begin
        st_nxt.mode = ST_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // Switching outputs
    // ----------------------------------------------------------------
    st_nxt.det1 = hyst(I_PROC_VAL, st_r.sp1, st_r.rp1, st_r.det1);
    st_nxt.det2 = hyst(I_PROC_VAL, st_r.sp2, st_r.rp2, st_r.det2);
    lvl1 = sw_out(st_r.ou1, st_r.det1, I_PROC_VAL, st_r.sp1, st_r.rp1);
    lvl2 = sw_out(st_r.fn2, st_r.det2, I_PROC_VAL, st_r.sp2, st_r.rp2);
    st_nxt.sw1 = lvl1 & ~I_TEACH_EN & ~I_SHORT1 & ~I_HW_FAIL;
    st_nxt.sw2 = lvl2 & ~I_SHORT2 & ~I_HW_FAIL;

    // ----------------------------------------------------------------
    // Indicator pattern
    // ----------------------------------------------------------------
    show = I_TEACH_EN ? lvl2 : lvl1;
    led.green = ~show;
    led.yellow = show;
    case (st_r.mode)
      ST_MEAS: begin
        led.green = 1'b0;
        led.yellow = (st_r.pulse >= ADJ_MAX_T) ? dbl1 : blink2;
      end
      ST_ADJ: begin
        led.green = 1'b0;
        led.yellow = blink2;
      end
      ST_LIT: begin
        led.green = 1'b1;
        led.yellow = 1'b1;
      end
      ST_FAULT: begin
        led.green = blink8;
        led.yellow = ~blink8;
      end
      default: begin
        if (I_HW_FAIL) begin
          led = '0;
        end else if (I_SHORT1 || I_SHORT2) begin
          led.green = 1'b0;
          led.yellow = blink2;
        end
      end
    endcase
    st_nxt.led1 = led;
    st_nxt.ind2 = led;

    // ----------------------------------------------------------------
    // Most urgent active event code
    // ----------------------------------------------------------------
    if (st_nxt.evt.hw) begin
      st_nxt.code = CODE_HW;
    end else if (st_nxt.evt.param) begin
      st_nxt.code = CODE_PARAM;
    end else if (st_nxt.evt.short_circ) begin
      st_nxt.code = CODE_SHORT;
    end else if (st_nxt.evt.test1) begin
      st_nxt.code = CODE_TEST1;
    end else if (st_nxt.evt.test2) begin
      st_nxt.code = CODE_TEST2;
    end else begin
      st_nxt.code = CODE_NONE;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      st_r <= ST_RESET;
    end else if (I_CE) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_SW1 = st_r.sw1;
  assign O_SW2 = st_r.sw2;
  assign O_LED1 = st_r.led1;
  assign O_IND2 = st_r.ind2;
  assign O_EVT = st_r.evt;
  assign O_EVT_CODE = st_r.code;
  assign O_OU1 = st_r.ou1;
  assign O_FN2 = st_r.fn2;
  assign O_TEACH_BUSY = (st_r.mode != ST_IDLE);

endmodule

`default_nettype wire

// *** tb/tio_teach_status_chk.sv ***
// Port assertions for the teach input and output status block
`timescale 1ns/10ps
`default_nettype none
module tio_chk (
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  input wire logic I_TEACH_EN,
  input wire logic I_SHORT1,
  input wire logic I_HW_FAIL,
  input wire tio_pkg::tio_cfg_t I_CFG,
  input wire logic I_FACTORY_RST,
  input wire logic I_IDX_WE,
  input wire logic [7:0] I_IDX_ADDR,
  input wire logic [7:0] I_IDX_DATA,
  input wire logic O_SW1,
  input wire logic O_SW2,
  input wire tio_pkg::tio_evt_t O_EVT,
  input wire logic [15:0] O_EVT_CODE,
  input wire tio_pkg::tio_func_t O_OU1,
  input wire tio_pkg::tio_func_t O_FN2,
  input wire logic O_TEACH_BUSY
);
  import tio_pkg::*;
  wire logic idx_go = I_CE && I_IDX_WE && I_IDX_ADDR == IDX_TEST;
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_SYS_RST);
  teach_sw1_a: assert property (I_TEACH_EN && I_CE |=> !O_SW1)
    else $error("first output on in teach mode");
  teach_gate_a: assert property (!I_TEACH_EN && !O_TEACH_BUSY && I_CE |=> !O_TEACH_BUSY)
    else $error("teach started while disabled");
  short_off_a: assert property (I_SHORT1 && I_CE |=> !O_SW1 && O_EVT.short_circ)
    else $error("short circuit not handled");
  hw_code_a: assert property (I_HW_FAIL && I_CE |=> O_EVT_CODE == CODE_HW && !O_SW1 && !O_SW2)
    else $error("hardware failure not reported");
  test_raise_a: assert property (idx_go && I_IDX_DATA == TEST1_SET |=> O_EVT.test1)
    else $error("first test event not raised");
  test_clear_a: assert property (idx_go && I_IDX_DATA == TEST2_CLR |=> !O_EVT.test2)
    else $error("second test event not cleared");
  factory_def_a: assert property (I_FACTORY_RST && I_CE |=> O_OU1 == FN_HNO && O_FN2 == FN_HNC)
    else $error("factory defaults not restored");
  cfg_reject_a: assert property (I_CFG.we && I_CE && !I_FACTORY_RST && I_CFG.sp2 <= I_CFG.rp2
    |=> O_EVT.param && O_FN2 == $past(O_FN2))
    else $error("bad thresholds accepted");
  busy_c: cover property ($rose(O_TEACH_BUSY));
  param_c: cover property (O_EVT.param);
  toggle_c: cover property ($changed(O_FN2));
endmodule
bind tio_teach_status tio_chk i_tio_chk (.I_SYS_CLK, .I_SYS_RST, .I_CE, .I_TEACH_EN, .I_SHORT1, .I_HW_FAIL,
  .I_CFG, .I_FACTORY_RST, .I_IDX_WE, .I_IDX_ADDR, .I_IDX_DATA, .O_SW1, .O_SW2, .O_EVT, .O_EVT_CODE,
  .O_OU1, .O_FN2, .O_TEACH_BUSY);
`default_nettype wire

// *** tb/tio_btn.sv ***
// Teach button model holding the shared pin high for a number of ticks
`timescale 1ns/10ps
`default_nettype none
module tio_btn #(
  parameter int TICK_CYC = 4
) (
  input wire logic i_clk,
  input wire logic i_press,
  input wire logic [7:0] i_ticks,
  output logic o_pin
);
  int cnt;
  initial begin
    o_pin = 1'h0;
    cnt = 0;
  end
  always @(posedge i_clk) begin
    if (i_press && !o_pin) begin
      o_pin <= 1'h1;
      cnt <= i_ticks * TICK_CYC;
    end else if (o_pin) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        o_pin <= 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the teach input and output status block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tio_pkg::*;
  localparam int TC = 4;
  typedef struct packed {
    logic [6:0] pv;
    logic [3:0] ctl;
    logic [1:0] sw;
    logic chk;
    logic [1:0] led;
  } tio_row_t;
  // Inputs {teach, short1, short2, hw}; expected {sw1, sw2}, led check, {green, yellow}
  tio_row_t rows[7] = '{{7'h14, 4'h0, 2'h1, 1'h1, 2'h2}, {7'h50, 4'h0, 2'h2, 1'h1, 2'h1},
    {7'h50, 4'h4, 2'h0, 1'h0, 2'h0}, {7'h14, 4'h2, 2'h0, 1'h0, 2'h0}, {7'h50, 4'h1, 2'h0, 1'h1, 2'h0},
    {7'h50, 4'h8, 2'h0, 1'h1, 2'h2}, {7'h14, 4'h8, 2'h1, 1'h1, 2'h1}};
  logic [7:0] dv[5] = '{TEST1_SET, TEST2_SET, TEST1_CLR, TEST2_CLR, TEST1_SET};
  logic [1:0] tv[5] = '{2'h2, 2'h3, 2'h1, 2'h0, 2'h0};
  logic [15:0] cv[5] = '{CODE_TEST1, CODE_TEST1, CODE_TEST2, CODE_NONE, CODE_NONE};
  logic [7:0] ft[4] = '{8'h32, 8'h14, 8'hC8, 8'h32};
  logic [6:0] fp[4] = '{7'h46, 7'h46, 7'h46, 7'h05};
  logic clk, rst, ten, s1, s2, hw, fr, iwe, press, pin, sw1, sw2, busy, ce;
  logic [6:0] pv;
  logic [7:0] iad, idt, nt;
  logic [15:0] code;
  tio_cfg_t cfg;
  tio_led_t led1, ind2;
  tio_evt_t evt;
  tio_func_t ou1, fn2;
  int fails, n_tests;
  tio_teach_status #(.TICK_CYC(TC)) i_tio_teach_status (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_CE(ce),
    .I_TEACH_EN(ten), .I_TEACH_PIN(pin), .I_PROC_VAL(pv), .I_SIG_AMBIG(1'h0), .I_SHORT1(s1), .I_SHORT2(s2),
    .I_HW_FAIL(hw), .I_CFG(cfg), .I_FACTORY_RST(fr), .I_IDX_WE(iwe), .I_IDX_ADDR(iad), .I_IDX_DATA(idt),
    .O_SW1(sw1), .O_SW2(sw2), .O_LED1(led1), .O_IND2(ind2), .O_EVT(evt), .O_EVT_CODE(code), .O_OU1(ou1),
    .O_FN2(fn2), .O_TEACH_BUSY(busy));
  tio_btn #(.TICK_CYC(TC)) i_tio_btn (.i_clk(clk), .i_press(press), .i_ticks(nt), .o_pin(pin));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ----
  // Tasks
  // ----
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wlo(input logic w);
    for (int i = 0; i < 4000; i++) begin
      if (!(w ? busy : pin)) return;
      cyc(1);
    end
    fails++;
    tally_and_finish;
  endtask
  task automatic idx(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {iad, idt, iwe} <= {a, d, 1'h1};
    @(posedge clk);
    iwe <= 1'h0;
    cyc(1);
  endtask
  task automatic wcfg(input tio_func_t f2, input logic [6:0] sp, input logic [6:0] rp);
    @(posedge clk);
    cfg <= '{we: 1'h1, ou1: FN_HNO, fn2: f2, sp1: SP_DFLT, rp1: RP_DFLT, sp2: sp, rp2: rp};
    @(posedge clk);
    cfg.we <= 1'h0;
    cyc(1);
  endtask
  task automatic teach(input logic [7:0] t);
    @(posedge clk);
    {nt, press} <= {t, 1'h1};
    @(posedge clk);
    press <= 1'h0;
    cyc(1);
    wlo(1'h0);
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    rst = 1'h1;
    {ten, s1, s2, hw, fr, iwe, press, iad, idt, nt} = '0;
    pv = 7'h14;
    cfg = '0;
    ce = 1'h1;
    fails = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    cyc(1);
    cmp("ou1", 16'(FN_HNO), 16'(ou1));
    cmp("second function", 16'(FN_HNC), 16'(fn2));
    cmp("sw2 idle", 16'h1, 16'(sw2));
    cmp("busy", 16'h0, 16'(busy));
    foreach (rows[i]) begin
      @(posedge clk);
      {pv, ten, s1, s2, hw} <= {rows[i].pv, rows[i].ctl};
      cyc(3);
      cmp("switches", 16'(rows[i].sw), 16'({sw1, sw2}));
      if (rows[i].chk) cmp("leds", 16'(rows[i].led), 16'(led1));
      if (rows[i].chk) cmp("second leds", 16'(rows[i].led), 16'(ind2));
    end
    @(posedge clk);
    ten <= 1'h0;
    for (int i = 0; i < 5; i++) begin
      idx(i == 4 ? 8'h03 : IDX_TEST, dv[i]);
      cmp("test events", 16'(tv[i]), 16'({evt.test1, evt.test2}));
      cmp("event code", cv[i], code);
    end
    @(posedge clk);
    ce <= 1'h0;
    idx(IDX_TEST, TEST1_SET);
    cmp("frozen event", 16'h0, 16'(evt.test1));
    @(posedge clk);
    ce <= 1'h1;
    @(posedge clk);
    s1 <= 1'h1;
    cyc(2);
    cmp("short code", CODE_SHORT, code);
    @(posedge clk);
    hw <= 1'h1;
    cyc(2);
    cmp("hw code", CODE_HW, code);
    @(posedge clk);
    {s1, hw} <= '0;
    wcfg(FN_HNO, 7'h30, 7'h30);
    cmp("param code", CODE_PARAM, code);
    cmp("function kept", 16'(FN_HNC), 16'(fn2));
    for (int f = 0; f < 4; f++) begin
      wcfg(tio_func_t'(f), SP_DFLT, RP_DFLT);
      cmp("function set", 16'(f), 16'(fn2));
    end
    @(posedge clk);
    ten <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      if (i == 1) begin
        @(posedge clk);
        fr <= 1'h1;
        @(posedge clk);
        fr <= 1'h0;
        cyc(1);
        cmp("factory function", 16'(FN_HNC), 16'(fn2));
      end
      @(posedge clk);
      pv <= fp[i];
      teach(ft[i]);
      cyc(8);
      cmp("fault busy", 16'h1, 16'(busy));
      cmp("fault leds", 16'h1, 16'(led1.green ^ led1.yellow));
      wlo(1'h1);
      cmp("function after fault", 16'(i == 0 ? FN_FNC : FN_HNC), 16'(fn2));
    end
    @(posedge clk);
    ten <= 1'h0;
    teach(8'h32);
    cyc(8);
    cmp("busy off", 16'h0, 16'(busy));
    @(posedge clk);
    {ten, pv} <= {1'h1, 7'h46};
    teach(8'h32);
    cyc(120);
    cmp("lit leds", 16'h3, 16'(led1));
    wlo(1'h1);
    @(posedge clk);
    pv <= 7'h3F;
    cyc(3);
    cmp("sw2 adjusted", 16'h1, 16'(sw2));
    @(posedge clk);
    pv <= 7'h14;
    for (int k = 0; k < 2; k++) begin
      teach(8'h64);
      cyc(2);
      cmp("function toggled", 16'(k ? FN_HNC : FN_HNO), 16'(fn2));
      wlo(1'h1);
      cyc(2);
      cmp("leds after", 16'(k ? 2'h1 : 2'h2), 16'(led1));
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
